// File: rtl/switch_queue_vlan_defs.svh
// Register offsets, field positions and reset values of the queue and VLAN entry bank
// Assumes inclusion by bare name from the design modules and the bench
`ifndef SWITCH_QUEUE_VLAN_DEFS_SVH
`define SWITCH_QUEUE_VLAN_DEFS_SVH
// Byte offsets within the 4 KB bus window
`define QMC_OFFSET 12'h390
`define W0_OFFSET 12'h400
`define W2_OFFSET 12'h408
`define CTRL_OFFSET 12'h40C
// Queue management control fields
`define QMC_MAP_MSB 7
`define QMC_MAP_LSB 6
`define QMC_DISCARD_BIT 1
`define QMC_RESET 8'h82
// Entry word 0 fields
`define W0_VALID_BIT 31
`define W0_FWD_SEL_BIT 27
`define W0_PRIO_MSB 26
`define W0_PRIO_LSB 24
`define W0_MSTP_MSB 14
`define W0_MSTP_LSB 12
`define W0_FID_MSB 6
`define W0_FID_LSB 0
// Entry word 2 fields
`define W2_PFWD_MSB 6
`define W2_PFWD_LSB 0
// Table access control fields
`define CTRL_INDEX_MSB 11
`define CTRL_INDEX_LSB 0
`define CTRL_ACTION_MSB 17
`define CTRL_ACTION_LSB 16
`define CTRL_START_BIT 23
// Reset values of staging and control state
`define ENTRY_RESET 22'h00_0000
`define INDEX_RESET 12'h000
`define ACTION_RESET 2'h0
`endif

// File: rtl/switch_queue_vlan_pkg.sv
// Types shared by the queue and VLAN entry bank
// Assumes the defs header sits beside it
package switch_queue_vlan_pkg;
	// Two-queue fold codes
	typedef enum logic [1:0] {
		MAP_ONE_HIGH = 2'h0,
		MAP_SPARE = 2'h1,
		MAP_HALF = 2'h2,
		MAP_THREE_HIGH = 2'h3
	} two_queue_priority_map_type;
	// Table access actions
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_WRITE = 2'h1,
		ACT_READ = 2'h2,
		ACT_CLEAR = 2'h3
	} table_action_type;
	// Access sequencer, one-hot
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b01,
		ACC_RUN = 2'b10
	} access_state_type;
	// One VLAN table entry
	typedef struct packed {
		logic valid;
		logic entry_forward_select;
		logic [2:0] prio;
		logic [2:0] mstp_index;
		logic [6:0] filter_identifier;
		logic [6:0] port_forward;
	} vlan_entry_type;
	// Frame facts for the membership check
	typedef struct packed {
		logic [6:0] dest_map;
		logic [6:0] member_map;
		logic mirror_active;
		logic mirror_other;
	} membership_frame_type;
endpackage

// File: rtl/queue_priority_fold.sv
// Folds a regenerated 2-bit priority onto a low or high queue
// Assumes clk and reset_n only feed the checks
`timescale 1ns/1ps
module queue_priority_fold
	import switch_queue_vlan_pkg::*;
(
	// Clock for checks
	input wire logic clk,
	input wire logic reset_n,
	// Fold code and priority
	input two_queue_priority_map_type map,
	input wire logic [1:0] prio,
	// Result
	output logic high
);
	// Threshold per fold code; the spare code behaves as the default code
	always_comb begin
		unique case (map)
			MAP_ONE_HIGH: high = (prio == 2'h3);
			MAP_HALF, MAP_SPARE: high = prio[1];
			MAP_THREE_HIGH: high = (prio != 2'h0);
		endcase
	end

	// Checks of the fold table
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_fold_low3;
		(map == MAP_ONE_HIGH) |-> (high == (prio == 2'h3));
	endproperty
	a_fold_low3: assert property (p_fold_low3) else $error("fold 00 wrong");
	property p_fold_half;
		(map == MAP_HALF) |-> (high == (prio >= 2'h2));
	endproperty
	a_fold_half: assert property (p_fold_half) else $error("fold 10 wrong");
	property p_fold_high3;
		(map == MAP_THREE_HIGH) |-> (high != (prio == 2'h0));
	endproperty
	a_fold_high3: assert property (p_fold_high3) else $error("fold 11 wrong");
endmodule

// File: rtl/vlan_entry_table.sv
// Flip-flop VLAN table with one access port and one lookup port
// Assumes the access sequencer issues at most one action per cycle
`timescale 1ns/1ps
`include "switch_queue_vlan_defs.svh"
module vlan_entry_table
	import switch_queue_vlan_pkg::*;
#(
	parameter int DEPTH = 4096,
	parameter int IDX_W = 12
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Access port
	input wire logic wr_en,
	input wire logic clear_all,
	input wire logic [IDX_W-1:0] acc_idx,
	input vlan_entry_type wr_entry,
	output vlan_entry_type rd_entry,
	// Lookup port
	input wire logic [IDX_W-1:0] look_idx,
	output vlan_entry_type look_entry
);
	vlan_entry_type mem [DEPTH];

	// Refuse sizes the index cannot serve
	if (DEPTH < 2 || DEPTH != (1 << IDX_W))
		$error("vlan_entry_table: DEPTH must be 2**IDX_W");

	// Storage changes only on reset or an action
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= `ENTRY_RESET;
			end
		end else if (ce) begin
			if (clear_all) begin
				for (int i = 0; i < DEPTH; i++) begin
					mem[i] <= `ENTRY_RESET;
				end
			end else if (wr_en) begin
				mem[acc_idx] <= wr_entry;
			end
		end
	end

	// Read ports
	assign rd_entry = mem[acc_idx];
	assign look_entry = mem[look_idx];

	// Checks of table updates
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_table_write;
		ce && wr_en && !clear_all |=> mem[$past(acc_idx)] == $past(wr_entry);
	endproperty
	a_table_write: assert property (p_table_write) else $error("table write lost");
	property p_table_clear;
		ce && clear_all |=> (mem[0] == `ENTRY_RESET) && (mem[DEPTH-1] == `ENTRY_RESET);
	endproperty
	a_table_clear: assert property (p_table_clear) else $error("table clear incomplete");
endmodule

// File: rtl/switch_queue_vlan_entry_regs.sv
// Overview of operation
// - In two-queue mode the fold field at bits 7:6, reset 10b, folds the 2-bit priority into two queues.
// - Fold code 00 puts priorities 0 to 2 low and 3 high; code 01 is spare.
// - Fold code 10 puts priorities 0 and 1 low and 2 and 3 high.
// - Fold code 11 puts only priority 0 low and 1 to 3 high.
// - With the discard bit (bit 1, reset 1) set, every frame is confined to its ingress membership ports.
// - With the discard bit clear, a single-destination frame is not confined to the membership ports.
// - With the discard bit clear, a single-destination frame with both mirror_active and mirror_other set is dropped.
// - An entry counts as valid only when bit 31 of entry word 0 is one.
// - Forward select bit 27 set sends matching frames to the entry's port forward map.
// - Forward select bit 27 clear takes the ports from the other forwarding sources.
// - Each entry holds a 3-bit priority in bits 26:24 of word 0.
// - Each entry holds a 3-bit spanning tree instance index in bits 14:12 of word 0.
// - Each entry holds a 7-bit filter identifier in bits 6:0, hashed with the MAC to index the lookup table.
// - The port forward field holds one bit per port, bits 6:0 for ports 7 to 1, used only with forward select.
// Assumes an AHB-Lite master with one slave and a single clock domain
`timescale 1ns/1ps
`include "switch_queue_vlan_defs.svh"
module switch_queue_vlan_entry_regs
	import switch_queue_vlan_pkg::*;
#(
	parameter int DEPTH = 4096,
	parameter int IDX_W = 12,
	parameter int HASH_W = 12
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Queue selection
	input wire logic two_queue_mode,
	input wire logic [1:0] regen_priority,
	output logic [1:0] queue_sel,
	// Membership check
	input membership_frame_type frame,
	output logic [6:0] fwd_map,
	output logic frame_drop,
	// Entry lookup
	input wire logic [IDX_W-1:0] look_vlan,
	input wire logic [47:0] look_mac,
	input wire logic [6:0] alu_map,
	output logic look_valid,
	output logic [2:0] look_prio,
	output logic [2:0] look_mstp,
	output logic [6:0] look_map,
	output logic [HASH_W-1:0] look_hash
);
	// Refuse widths the logic cannot serve
	if (IDX_W > 12 || HASH_W < 1 || HASH_W > 32)
		$error("switch_queue_vlan_entry_regs: bad IDX_W or HASH_W");

	logic [7:0] qmc;
	vlan_entry_type stage;
	logic [11:0] vlan_index;
	table_action_type action;
	access_state_type acc_state;
	logic wpend;
	logic [11:0] waddr;
	logic wcommit;
	logic addr_ok;
	logic rd_clash;
	logic table_wr;
	logic table_clear;
	logic fold_high;
	logic single_dest;
	logic discard;
	vlan_entry_type rd_entry;
	vlan_entry_type look_entry;

	// Fold a key of filter identifier and MAC into the hash width
	function automatic logic [HASH_W-1:0] fold_hash(input logic [54:0] key);
		logic [HASH_W-1:0] acc;
		acc = '0;
		for (int i = 0; i < 55; i++) begin
			acc[i % HASH_W] = acc[i % HASH_W] ^ key[i];
		end
		return acc;
	endfunction

	// Register read view; reserved bits read zero
	function automatic logic [31:0] read_mux(input logic [11:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`QMC_OFFSET: v[7:0] = qmc;
			`W0_OFFSET: begin
				v[`W0_VALID_BIT] = stage.valid;
				v[`W0_FWD_SEL_BIT] = stage.entry_forward_select;
				v[`W0_PRIO_MSB:`W0_PRIO_LSB] = stage.prio;
				v[`W0_MSTP_MSB:`W0_MSTP_LSB] = stage.mstp_index;
				v[`W0_FID_MSB:`W0_FID_LSB] = stage.filter_identifier;
			end
			`W2_OFFSET: v[`W2_PFWD_MSB:`W2_PFWD_LSB] = stage.port_forward;
			`CTRL_OFFSET: begin
				v[`CTRL_START_BIT] = (acc_state == ACC_RUN);
				v[`CTRL_ACTION_MSB:`CTRL_ACTION_LSB] = action;
				v[`CTRL_INDEX_MSB:`CTRL_INDEX_LSB] = vlan_index;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Bus handshake; a read waits one cycle behind a pending write
	assign addr_ok = ce & hsel & hready & htrans[1];
	assign rd_clash = wpend & hsel & htrans[1] & ~hwrite;
	assign hreadyout = ce & ~rd_clash;
	assign hresp = 1'b0;
	assign wcommit = ce & wpend;

	// Write data phase tracking
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wpend <= 1'b0;
			waddr <= 12'h000;
		end else if (ce) begin
			wpend <= addr_ok & hwrite;
			if (addr_ok & hwrite) begin
				waddr <= haddr[11:0];
			end
		end
	end

	// Read data captured in the address phase
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok & ~hwrite) begin
			hrdata <= read_mux(haddr[11:0]);
		end
	end

	// Queue management control; all eight low bits are writable
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			qmc <= `QMC_RESET;
		end else if (wcommit && waddr == `QMC_OFFSET) begin
			qmc <= hwdata[7:0];
		end
	end
	assign discard = qmc[`QMC_DISCARD_BIT];

	// Staging entry; a table read load wins over a bus write
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage <= `ENTRY_RESET;
		end else if (ce) begin
			if (acc_state == ACC_RUN && action == ACT_READ) begin
				stage <= rd_entry;
			end else if (wcommit && waddr == `W0_OFFSET) begin
				stage.valid <= hwdata[`W0_VALID_BIT];
				stage.entry_forward_select <= hwdata[`W0_FWD_SEL_BIT];
				stage.prio <= hwdata[`W0_PRIO_MSB:`W0_PRIO_LSB];
				stage.mstp_index <= hwdata[`W0_MSTP_MSB:`W0_MSTP_LSB];
				stage.filter_identifier <= hwdata[`W0_FID_MSB:`W0_FID_LSB];
			end else if (wcommit && waddr == `W2_OFFSET) begin
				stage.port_forward <= hwdata[`W2_PFWD_MSB:`W2_PFWD_LSB];
			end
		end
	end

	// Index and action, held while an action runs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vlan_index <= `INDEX_RESET;
			action <= table_action_type'(`ACTION_RESET);
		end else if (wcommit && waddr == `CTRL_OFFSET && acc_state == ACC_IDLE) begin
			vlan_index <= hwdata[`CTRL_INDEX_MSB:`CTRL_INDEX_LSB];
			action <= table_action_type'(hwdata[`CTRL_ACTION_MSB:`CTRL_ACTION_LSB]);
		end
	end

	// Access sequencer; start clears itself after one action cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			acc_state <= ACC_IDLE;
		end else if (ce) begin
			unique case (acc_state)
				ACC_IDLE: begin
					if (wcommit && waddr == `CTRL_OFFSET && hwdata[`CTRL_START_BIT]) begin
						acc_state <= ACC_RUN;
					end
				end
				ACC_RUN: acc_state <= ACC_IDLE;
				default: acc_state <= ACC_IDLE;
			endcase
		end
	end
	assign table_wr = (acc_state == ACC_RUN) && (action == ACT_WRITE);
	assign table_clear = (acc_state == ACC_RUN) && (action == ACT_CLEAR);

	// Entry storage
	vlan_entry_table #(
		.DEPTH(DEPTH),
		.IDX_W(IDX_W)
	) u_table (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.wr_en(table_wr),
		.clear_all(table_clear),
		.acc_idx(vlan_index[IDX_W-1:0]),
		.wr_entry(stage),
		.rd_entry(rd_entry),
		.look_idx(look_vlan),
		.look_entry(look_entry)
	);

	// Priority fold
	queue_priority_fold u_fold (
		.clk(clk),
		.reset_n(reset_n),
		.map(two_queue_priority_map_type'(qmc[`QMC_MAP_MSB:`QMC_MAP_LSB])),
		.prio(regen_priority),
		.high(fold_high)
	);

	// Queue choice; four-queue mode passes the priority through
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			queue_sel <= 2'h0;
		end else if (ce) begin
			queue_sel <= two_queue_mode ? {1'b0, fold_high} : regen_priority;
		end
	end

	// Membership confinement and mirror drop
	assign single_dest = $onehot(frame.dest_map);
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fwd_map <= 7'h00;
			frame_drop <= 1'b0;
		end else if (ce) begin
			if (discard || !single_dest) begin
				fwd_map <= frame.dest_map & frame.member_map;
				frame_drop <= 1'b0;
			end else if (frame.mirror_active && frame.mirror_other) begin
				fwd_map <= 7'h00;
				frame_drop <= 1'b1;
			end else begin
				fwd_map <= frame.dest_map;
				frame_drop <= 1'b0;
			end
		end
	end

	// Lookup result; fields count only for a valid entry, except the filter identifier, which always feeds the hash
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			look_valid <= 1'b0;
			look_prio <= 3'h0;
			look_mstp <= 3'h0;
			look_map <= 7'h00;
			look_hash <= '0;
		end else if (ce) begin
			look_valid <= look_entry.valid;
			look_prio <= look_entry.valid ? look_entry.prio : 3'h0;
			look_mstp <= look_entry.valid ? look_entry.mstp_index : 3'h0;
			if (look_entry.valid && look_entry.entry_forward_select) begin
				look_map <= look_entry.port_forward;
			end else begin
				look_map <= alu_map;
			end
			look_hash <= fold_hash({look_entry.filter_identifier, look_mac});
		end
	end

	// Checks wait for one enabled edge after reset release
	logic chk_live;
	always_ff @(posedge clk) chk_live <= reset_n & (chk_live | ce);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n || !chk_live);
	property p_fold_reset;
		$rose(reset_n) |-> (qmc[`QMC_MAP_MSB:`QMC_MAP_LSB] == 2'h2) && discard;
	endproperty
	a_fold_reset: assert property (p_fold_reset) else $error("control reset value wrong");
	property p_confine;
		ce && discard |=> ((fwd_map & ~$past(frame.member_map)) == 7'h00);
	endproperty
	a_confine: assert property (p_confine) else $error("frame left membership");
	property p_single_free;
		ce && !discard && single_dest && !frame.mirror_active |=> fwd_map == $past(frame.dest_map) && !frame_drop;
	endproperty
	a_single_free: assert property (p_single_free) else $error("single frame confined");
	property p_mirror_drop;
		ce && !discard && single_dest && frame.mirror_active && frame.mirror_other |=> frame_drop && fwd_map == 7'h00;
	endproperty
	a_mirror_drop: assert property (p_mirror_drop) else $error("mirrored frame kept");
	property p_invalid;
		ce && !look_entry.valid |=> !look_valid && look_map == $past(alu_map);
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid entry used");
	property p_fwd_entry;
		ce && look_entry.valid && look_entry.entry_forward_select |=> look_map == $past(look_entry.port_forward);
	endproperty
	a_fwd_entry: assert property (p_fwd_entry) else $error("entry map not used");
	property p_fwd_other;
		ce && look_entry.valid && !look_entry.entry_forward_select |=> look_map == $past(alu_map);
	endproperty
	a_fwd_other: assert property (p_fwd_other) else $error("other map not used");
	sequence s_w0_write;
		wcommit && waddr == `W0_OFFSET && acc_state == ACC_IDLE;
	endsequence
	property p_prio_field;
		s_w0_write |=> stage.prio == $past(hwdata[26:24]) ##1
			(hrdata[26:24] == $past(stage.prio) || !$past(addr_ok && !hwrite && haddr[11:0] == `W0_OFFSET));
	endproperty
	a_prio_field: assert property (p_prio_field) else $error("priority field misplaced");
	property p_mstp_field;
		s_w0_write |=> stage.mstp_index == $past(hwdata[14:12]);
	endproperty
	a_mstp_field: assert property (p_mstp_field) else $error("spanning tree index misplaced");
	property p_fid_field;
		s_w0_write |=> stage.filter_identifier == $past(hwdata[6:0]) && stage.valid == $past(hwdata[31]);
	endproperty
	a_fid_field: assert property (p_fid_field) else $error("filter identifier misplaced");
	property p_pfwd_field;
		wcommit && waddr == `W2_OFFSET && acc_state == ACC_IDLE |=> stage.port_forward == $past(hwdata[6:0]);
	endproperty
	a_pfwd_field: assert property (p_pfwd_field) else $error("port forward misplaced");
	property p_staged_only;
		(table_wr || table_clear) |->
			($past(acc_state == ACC_RUN && !ce) || $past(wcommit && waddr == `CTRL_OFFSET && hwdata[`CTRL_START_BIT]))
			##1 (acc_state == ACC_IDLE || !$past(ce));
	endproperty
	a_staged_only: assert property (p_staged_only) else $error("table touched without action");
	c_write_action: cover property (ce && table_wr);
	c_read_action: cover property (ce && acc_state == ACC_RUN && action == ACT_READ);
	c_mirror_drop: cover property (frame_drop);
	c_entry_forward: cover property (look_valid && ce && look_entry.entry_forward_select);
endmodule

// File: sim/switch_queue_vlan_entry_regs_bench.sv
// Self-checking bench for the queue control and VLAN entry staging bank
// Assumes the bench is the only AHB-Lite master and the table is shrunk to 16 entries
`timescale 1ns/1ps
`include "switch_queue_vlan_defs.svh"
module switch_queue_vlan_entry_regs_bench;
	import switch_queue_vlan_pkg::*;

	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b1;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic two_queue_mode = 1'b0;
	logic [1:0] regen_priority = 2'h0;
	logic [1:0] queue_sel;
	membership_frame_type frame = '0;
	logic [6:0] fwd_map;
	logic frame_drop;
	logic [3:0] look_vlan = '0;
	logic [47:0] look_mac = '0;
	logic [6:0] alu_map = '0;
	logic look_valid;
	logic [2:0] look_prio;
	logic [2:0] look_mstp;
	logic [6:0] look_map;
	logic [11:0] look_hash;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] rd;

	// Clock at 50 MHz
	always #10 clk = ~clk;

	switch_queue_vlan_entry_regs #(.DEPTH(16), .IDX_W(4), .HASH_W(12)) i_dut (
		.clk(clk), .reset_n(reset_n), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.two_queue_mode(two_queue_mode), .regen_priority(regen_priority), .queue_sel(queue_sel),
		.frame(frame), .fwd_map(fwd_map), .frame_drop(frame_drop),
		.look_vlan(look_vlan), .look_mac(look_mac), .alu_map(alu_map), .look_valid(look_valid),
		.look_prio(look_prio), .look_mstp(look_mstp), .look_map(look_map), .look_hash(look_hash)
	);

	// Verdict and end of run
	task automatic tally_and_finish();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Waits for hready sampled high at a rising edge
	task automatic wait_ready();
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask

	task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {20'h0_0000, a};
		hwrite <= 1'b1;
		wait_ready();
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= d;
		wait_ready();
	endtask

	task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {20'h0_0000, a};
		hwrite <= 1'b0;
		wait_ready();
		htrans <= 2'h0;
		wait_ready();
		d = hrdata;
	endtask

	task automatic read_check(input logic [11:0] a, input logic [31:0] exp);
		ahb_read(a, rd);
		check(rd, exp);
	endtask

	// Starts a table action and polls until start reads back clear
	task automatic table_action(input logic [1:0] act, input logic [11:0] idx);
		int n;
		n = 0;
		ahb_write(`CTRL_OFFSET, {8'h00, 1'b1, 5'h00, act, 4'h0, idx});
		do begin
			ahb_read(`CTRL_OFFSET, rd);
			n++;
		end while (rd[23] !== 1'b0 && n < 20);
		check({31'h0, rd[23]}, 32'h0000_0000);
	endtask

	// Lets registered outputs follow held inputs
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// XOR fold of filter id and MAC into the hash width
	function automatic logic [11:0] fold(input logic [54:0] v);
		logic [11:0] h;
		h = '0;
		for (int i = 0; i < 55; i++) begin
			h[i % 12] = h[i % 12] ^ v[i];
		end
		return h;
	endfunction

	task automatic frame_case(input logic disc, input logic [6:0] dm, input logic [6:0] mm,
		input logic ma, input logic mo, input logic [6:0] exp_map, input logic exp_drop);
		ahb_write(`QMC_OFFSET, {24'h00_0000, 2'h2, 4'h0, disc, 1'b0});
		frame <= '{dest_map: dm, member_map: mm, mirror_active: ma, mirror_other: mo};
		settle();
		check({25'h0, fwd_map}, {25'h0, exp_map});
		check({31'h0, frame_drop}, {31'h0, exp_drop});
	endtask

	initial begin
		logic exp_high;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		// Reset values and read-only bits
		read_check(`QMC_OFFSET, 32'h0000_0082);
		read_check(`W0_OFFSET, 32'h0000_0000);
		ahb_write(`QMC_OFFSET, 32'hFFFF_FFFF);
		read_check(`QMC_OFFSET, 32'h0000_00FF);
		ahb_write(`W0_OFFSET, 32'hFFFF_FFFF);
		read_check(`W0_OFFSET, 32'h8F00_707F);
		// Unmapped place
		ahb_write(12'h3F0, 32'h1234_5678);
		read_check(12'h3F0, 32'h0000_0000);
		// Every fold code against every priority
		two_queue_mode <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			ahb_write(`QMC_OFFSET, {24'h00_0000, c[1:0], 6'h02});
			for (int p = 0; p < 4; p++) begin
				regen_priority <= p[1:0];
				settle();
				exp_high = (c == 0) ? (p == 3) : (c == 3) ? (p >= 1) : (p >= 2);
				check({30'h0, queue_sel}, {31'h0, exp_high});
			end
		end
		two_queue_mode <= 1'b0;
		regen_priority <= 2'h3;
		settle();
		check({30'h0, queue_sel}, 32'h0000_0003);
		// Clock enable low freezes state and stalls the bus
		ce <= 1'b0;
		regen_priority <= 2'h1;
		settle();
		check({30'h0, queue_sel}, 32'h0000_0003);
		check({31'h0, hreadyout}, 32'h0000_0000);
		ce <= 1'b1;
		settle();
		check({30'h0, queue_sel}, 32'h0000_0001);
		// Membership confinement and mirror drop
		frame_case(1'b1, 7'h01, 7'h03, 1'b1, 1'b1, 7'h01, 1'b0);
		frame_case(1'b1, 7'h0C, 7'h04, 1'b0, 1'b0, 7'h04, 1'b0);
		frame_case(1'b0, 7'h10, 7'h01, 1'b0, 1'b0, 7'h10, 1'b0);
		frame_case(1'b0, 7'h10, 7'h01, 1'b1, 1'b0, 7'h10, 1'b0);
		frame_case(1'b0, 7'h10, 7'h01, 1'b1, 1'b1, 7'h00, 1'b1);
		frame_case(1'b0, 7'h30, 7'h10, 1'b0, 1'b0, 7'h10, 1'b0);
		// Staging only reaches the table on a started action
		ahb_write(`W0_OFFSET, 32'h8D00_5045);
		ahb_write(`W2_OFFSET, 32'h0000_0055);
		look_vlan <= 4'h3;
		look_mac <= 48'hA1B2_C3D4_E5F6;
		alu_map <= 7'h2A;
		settle();
		check({31'h0, look_valid}, 32'h0000_0000);
		check({25'h0, look_map}, 32'h0000_002A);
		table_action(2'h1, 12'h003);
		settle();
		check({31'h0, look_valid}, 32'h0000_0001);
		check({29'h0, look_prio}, 32'h0000_0005);
		check({29'h0, look_mstp}, 32'h0000_0005);
		check({25'h0, look_map}, 32'h0000_0055);
		check({20'h0, look_hash}, {20'h0, fold({7'h45, 48'hA1B2_C3D4_E5F6})});
		// Entry without forward select takes the other map
		ahb_write(`W0_OFFSET, 32'h8200_2011);
		table_action(2'h1, 12'h005);
		look_vlan <= 4'h5;
		settle();
		check({25'h0, look_map}, 32'h0000_002A);
		check({29'h0, look_prio}, 32'h0000_0002);
		check({20'h0, look_hash}, {20'h0, fold({7'h11, 48'hA1B2_C3D4_E5F6})});
		// Table read reloads the staging words
		ahb_write(`W0_OFFSET, 32'h0000_0000);
		ahb_write(`W2_OFFSET, 32'h0000_0000);
		table_action(2'h2, 12'h003);
		read_check(`W0_OFFSET, 32'h8D00_5045);
		read_check(`W2_OFFSET, 32'h0000_0055);
		// Clear all leaves entry 3 invalid
		table_action(2'h3, 12'h000);
		look_vlan <= 4'h3;
		settle();
		check({31'h0, look_valid}, 32'h0000_0000);
		check({29'h0, look_prio}, 32'h0000_0000);
		check({25'h0, look_map}, 32'h0000_002A);
		// Deselected writes are ignored
		ahb_write(`QMC_OFFSET, 32'h0000_0040);
		hsel <= 1'b0;
		ahb_write(`QMC_OFFSET, 32'h0000_00C2);
		hsel <= 1'b1;
		read_check(`QMC_OFFSET, 32'h0000_0040);
		check({31'h0, hresp}, 32'h0000_0000);
		// Mid-run reset restores defaults and empties staging
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		read_check(`QMC_OFFSET, 32'h0000_0082);
		read_check(`W0_OFFSET, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
